// ### tb.sv
// Purpose: self-checking bench for the host bus port
// Assumes: WAIT_CYCLES shortened to 2
// Notes: register file stands in as a constant read value
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import vhp_pkg::*;
	logic clock = 1'b0, rst = 1'b1, cs_n = 1'b0, aen = 1'b0, system_refresh_n = 1'b1;
	logic irq_enabled = 1'b0, vsync_pending = 1'b0;
	logic [3:0] latched_upper_address = 4'h3, strb_n;
	logic [19:0] addr;
	logic [15:0] data_in, data_out;
	logic ale, bhe_n, lo_n, hi_n, dir, rdy, rdy_oe, cs16_n, irq, reg_wr, oe;
	logic [7:0] reg_index, reg_wdata, io_addr_reg;
	logic [1:0] global_enable;
	int failures = 0, n_compared = 0, n_wr = 0, n_oe = 0;
	always #4 clock = ~clock;
	always @(posedge clock) if (reg_wr === 1'b1) n_wr <= n_wr + 1;
	always @(posedge clock) if (oe === 1'b1) n_oe <= n_oe + 1;
	vhp_host_port #(.WAIT_CYCLES(2)) dut (.clock, .rst, .addr, .latched_upper_address, .ale, .aen,
		.byte_high_enable_n(bhe_n), .system_refresh_n, .mem_rd_n(strb_n[2]), .mem_wr_n(strb_n[3]),
		.io_rd_n(strb_n[0]), .io_wr_n(strb_n[1]), .cs_n, .data_in, .data_out, .data_oe(oe),
		.xcvr_low_byte_en_n(lo_n), .xcvr_high_byte_en_n(hi_n), .xcvr_dir(dir), .ready_out(rdy),
		.ready_oe(rdy_oe), .memcs16_n(cs16_n), .irq, .vsync_pending, .irq_enabled,
		.mem_base(4'h3), .mem_busy(1'b0), .mem_sel(), .mem_lanes(), .reg_index, .reg_wr,
		.reg_wdata, .reg_rdata(8'h5A), .io_addr_reg, .global_enable);
	vhp_host_bfm host (.clock, .ready_out(rdy), .ready_oe(rdy_oe), .memcs16_n(cs16_n),
		.xcvr_dir(dir), .xcvr_low_byte_en_n(lo_n), .xcvr_high_byte_en_n(hi_n), .data_out,
		.addr, .ale, .bhe_n, .strb_n, .data_in);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// strap held well around the release edge
	task automatic do_reset(input logic strap);
		@(posedge clock);
		rst <= 1'b1;
		cs_n <= strap;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		cs_n <= 1'b0;
	endtask
	task automatic t_fixed;
		do_reset(1'b0);
		chk(16'(io_addr_reg), 16'hD6);
		host.cyc(1, 20'h00AD6, 16'h0011, 1'b0);
		chk(16'(reg_index), 16'h11);
		cs_n <= 1'b1;
		host.cyc(1, 20'h00AD6, 16'h0022, 1'b0);
		chk(16'(reg_index), 16'h11);
		cs_n <= 1'b0;
		aen <= 1'b1;
		host.cyc(1, 20'h00AD6, 16'h0033, 1'b0);
		chk(16'(reg_index), 16'h11);
		chk(16'(host.seen[1:0]), 16'h0);
		aen <= 1'b0;
	endtask
	task automatic t_enable;
		int n0, n1;
		n1 = n_oe;
		host.cyc(0, 20'h00AD7, 16'h0000, 1'b0);
		chk(host.rdata, 16'h0000);
		chk(16'(n_oe - n1), 16'h0);
		host.cyc(1, 20'h00AD6, 16'h00FF, 1'b0);
		host.cyc(1, 20'h00AD7, 16'h01FE, 1'b0);
		chk(16'(global_enable), 16'h1);
		host.cyc(1, 20'h00AD6, 16'h0010, 1'b0);
		n0 = n_wr;
		host.cyc(1, 20'h00AD7, 16'h9C63, 1'b0);
		chk(16'(reg_wdata), 16'h9C);
		chk(16'(n_wr - n0), 16'h1);
		chk(16'(host.seen), 16'h06);
		n1 = n_oe;
		host.cyc(0, 20'h00AD7, 16'h0000, 1'b0);
		chk(host.rdata, 16'h5A5A);
		chk(16'(n_oe - n1), 16'h5);
		chk(16'(host.seen), 16'h02);
		chk(16'(reg_index), 16'h10);
	endtask
	task automatic t_mem;
		host.cyc(2, 20'h12344, 16'h0000, 1'b1);
		chk(16'(host.seen[5:2]), 16'h0);
		host.cyc(1, 20'h00AD6, 16'h00FF, 1'b0);
		host.cyc(1, 20'h00AD7, 16'h0300, 1'b0);
		host.cyc(2, 20'h12344, 16'h0000, 1'b1);
		chk(16'(host.seen), 16'h3B);
		chk(16'(rdy_oe), 16'h0);
		system_refresh_n <= 1'b0;
		host.cyc(2, 20'h12344, 16'h0000, 1'b1);
		chk(16'(host.seen[3:2]), 16'h0);
		system_refresh_n <= 1'b1;
		// upper bits move after the latch falls, so the cycle must still hit
		fork
			host.cyc(3, 20'h12344, 16'hBEEF, 1'b1);
			begin
				repeat (6) @(posedge clock);
				latched_upper_address <= 4'h4;
			end
		join
		chk(16'(host.seen[3:1]), 16'h7);
		host.cyc(3, 20'h12344, 16'hBEEF, 1'b1);
		chk(16'(host.seen[5:2]), 16'h0);
		latched_upper_address <= 4'h3;
	endtask
	task automatic t_irq;
		irq_enabled <= 1'b1;
		repeat (2) @(posedge clock);
		chk(16'(irq), 16'h0);
		vsync_pending <= 1'b1;
		repeat (2) @(posedge clock);
		chk(16'(irq), 16'h1);
	endtask
	task automatic t_prog;
		do_reset(1'b1);
		chk(16'(global_enable), 16'h0);
		host.cyc(1, 20'h00300, 16'h0033, 1'b0);
		chk(16'(io_addr_reg), 16'h33);
		host.cyc(1, 20'h01032, 16'h0044, 1'b0);
		chk(16'(reg_index), 16'h44);
		host.cyc(1, 20'h00034, 16'h0055, 1'b0);
		chk(16'(reg_index), 16'h44);
	endtask
	initial begin
		t_fixed;
		t_enable;
		t_mem;
		t_irq;
		t_prog;
		finish_test;
	end
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		finish_test;
	end
endmodule
`default_nettype wire

// ### vhp_host_bfm.sv
// Purpose: bus master model driving the host port pins
// Assumes: pins move just after a rising edge
// Notes: strobe held five edges, longer while ready is held low
`default_nettype none
module vhp_host_bfm (
	input wire logic clock,
	input wire logic ready_out,
	input wire logic ready_oe,
	input wire logic memcs16_n,
	input wire logic xcvr_dir,
	input wire logic xcvr_low_byte_en_n,
	input wire logic xcvr_high_byte_en_n,
	input wire logic [15:0] data_out,
	output logic [19:0] addr,
	output logic ale,
	output logic bhe_n,
	output logic [3:0] strb_n,
	output logic [15:0] data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rdata = '0;
	logic [5:0] seen = '0;
	initial begin
		addr = '0;
		ale = 1'b0;
		bhe_n = 1'b1;
		strb_n = 4'hF;
		data_in = '0;
	end
	// k: 0 io read, 1 io write, 2 memory read, 3 memory write
	task automatic cyc(input int k, input logic [19:0] a, input logic [15:0] d, input logic w);
		int i;
		@(posedge clock);
		addr <= a;
		bhe_n <= ~(a[0] | w);
		ale <= 1'b1;
		data_in <= d;
		seen <= '0;
		@(posedge clock);
		ale <= 1'b0;
		@(posedge clock);
		strb_n[k] <= 1'b0;
		// ready sampled at each edge; no release while it is held low, for up to 40 edges
		for (i = 0; i < 40 && (i < 5 || (ready_oe && !ready_out)); i++) begin
			@(posedge clock);
			// answers trail the pins by the synchroniser; direction counts with a lane open
			if (i >= 2) begin
				seen <= seen | {!memcs16_n, ready_oe & ready_out, ready_oe & !ready_out,
					xcvr_dir & !(xcvr_low_byte_en_n & xcvr_high_byte_en_n),
					!xcvr_high_byte_en_n, !xcvr_low_byte_en_n};
			end
		end
		rdata <= data_out;
		strb_n[k] <= 1'b1;
		// released data lines must not keep the last value
		data_in <= ~d;
		repeat (4) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// ### vhp_host_port.sv
// Purpose: host bus port: decode, index/data pair, byte steering, ready
// Assumes: register file outside, reached by reg_* ports
// Notes: all bus pins pass two flip-flops, so answers trail pins
`default_nettype none
module vhp_host_port
	import vhp_pkg::*;
#(
	parameter int WAIT_CYCLES = VHP_WAIT_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [19:0] addr,
	input wire logic [3:0] latched_upper_address,
	input wire logic ale,
	input wire logic aen,
	input wire logic byte_high_enable_n,
	input wire logic system_refresh_n,
	input wire logic mem_rd_n,
	input wire logic mem_wr_n,
	input wire logic io_rd_n,
	input wire logic io_wr_n,
	input wire logic cs_n,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe,
	output logic xcvr_low_byte_en_n,
	output logic xcvr_high_byte_en_n,
	output logic xcvr_dir,
	output logic ready_out,
	output logic ready_oe,
	output logic memcs16_n,
	output logic irq,
	input wire logic vsync_pending,
	input wire logic irq_enabled,
	input wire logic [3:0] mem_base,
	input wire logic mem_busy,
	output logic mem_sel,
	output logic [1:0] mem_lanes,
	output logic [7:0] reg_index,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] io_addr_reg,
	output logic [1:0] global_enable
);
	if (WAIT_CYCLES < 1 || WAIT_CYCLES > 255) begin
		$error("wait cycles out of range");
	end
	logic [19:0] a_s;
	logic [3:0] la_s;
	logic [15:0] d_s;
	logic [9:0] c_s;
	vhp_sync #(.WIDTH(20)) sync_a (.clock(clock), .rst(rst), .d(addr), .q(a_s));
	vhp_sync #(.WIDTH(4)) sync_la (.clock(clock), .rst(rst), .d(latched_upper_address), .q(la_s));
	vhp_sync #(.WIDTH(16)) sync_d (.clock(clock), .rst(rst), .d(data_in), .q(d_s));
	// ale comes out of reset at its idle low level, so no false latch edge
	vhp_sync #(.WIDTH(10), .INIT(10'h1FE)) sync_c (.clock(clock), .rst(rst),
		.d({ale, aen, byte_high_enable_n, system_refresh_n, mem_rd_n, mem_wr_n,
			io_rd_n, io_wr_n, cs_n, 1'b0}), .q(c_s));
	logic ale_s, aen_s, bhe_s, system_refresh_n_s, mrd_s, mwr_s, iord_s, iowr_s, cs_s;
	assign {ale_s, aen_s, bhe_s, system_refresh_n_s, mrd_s, mwr_s, iord_s, iowr_s, cs_s} = c_s[9:1];
	logic ale_d_reg, iowr_d_reg, iord_d_reg;
	logic [2:0] rst_d_reg;
	logic [3:0] la_reg;
	logic [19:0] a_reg;
	always_ff @(posedge clock) begin
		if (rst) begin
			ale_d_reg <= 1'b0;
			iowr_d_reg <= 1'b1;
			iord_d_reg <= 1'b1;
		end else begin
			ale_d_reg <= ale_s;
			iowr_d_reg <= iowr_s;
			iord_d_reg <= iord_s;
		end
	end
	// latched address follows ale; capture on its falling edge
	always_ff @(posedge clock) begin
		if (rst) begin
			la_reg <= 4'h0;
			a_reg <= 20'h00000;
		end else if (ale_d_reg && !ale_s) begin
			la_reg <= la_s;
			a_reg <= a_s;
		end
	end
	// strap read two edges late: the synchroniser sits in reset until release
	logic prog_wait_reg, strap_edge;
	assign strap_edge = rst_d_reg[2] && !rst_d_reg[1];
	always_ff @(posedge clock) begin
		rst_d_reg <= {rst_d_reg[1:0], rst};
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			prog_wait_reg <= 1'b0;
		end else if (strap_edge) begin
			prog_wait_reg <= cs_s;
		end else if (prog_wait_reg && !iowr_s && !cs_s && !aen_s) begin
			prog_wait_reg <= 1'b0;
		end
	end
	logic io_hit, io_active, io_wr_pulse, io_rd_start;
	assign io_hit = !cs_s && !aen_s && !prog_wait_reg
		&& (a_s[7:1] == io_addr_reg[7:1]);
	assign io_active = io_hit && (!iord_s || !iowr_s);
	assign io_wr_pulse = iowr_d_reg && !iowr_s && !aen_s;
	assign io_rd_start = iord_d_reg && !iord_s;
	// odd byte rides d15:8 while the high enable is low
	function automatic logic [7:0] vhp_pick_byte(input logic [15:0] d, input logic bhe_n,
		input logic a0);
		vhp_pick_byte = (!bhe_n && a0) ? d[15:8] : d[7:0];
	endfunction
	logic [7:0] io_byte;
	assign io_byte = vhp_pick_byte(d_s, bhe_s, a_s[0]);
	always_ff @(posedge clock) begin
		if (rst) begin
			io_addr_reg <= VHP_FIXED_ADDR;
		end else if (strap_edge && !cs_s) begin
			io_addr_reg <= VHP_FIXED_ADDR;
		end else if (prog_wait_reg && io_wr_pulse && !cs_s) begin
			io_addr_reg <= io_byte;
		end
	end
	// index write at even location; held across data port use
	always_ff @(posedge clock) begin
		if (rst) begin
			reg_index <= 8'h00;
		end else if (io_hit && io_wr_pulse && !a_s[0]) begin
			reg_index <= io_byte;
		end
	end
	logic data_wr;
	assign data_wr = io_hit && io_wr_pulse && a_s[0];
	always_ff @(posedge clock) begin
		if (rst) begin
			global_enable <= 2'b00;
		end else if (data_wr && reg_index == VHP_GLOBAL_INDEX) begin
			global_enable <= io_byte[1:0];
		end
	end
	logic reg_open;
	assign reg_open = global_enable[VHP_REG_EN_BIT];
	always_ff @(posedge clock) begin
		if (rst) begin
			reg_wr <= 1'b0;
			reg_wdata <= 8'h00;
		end else begin
			reg_wr <= data_wr && reg_open && reg_index != VHP_GLOBAL_INDEX;
			if (data_wr) begin
				reg_wdata <= io_byte;
			end
		end
	end
	// memory decode: linear window at the 1M block named by mem_base
	logic mem_req, mem_region;
	assign mem_region = global_enable[VHP_MEM_EN_BIT] && la_reg == mem_base;
	assign mem_req = mem_region && system_refresh_n_s && (!mrd_s || !mwr_s);
	assign memcs16_n = !mem_region;
	assign mem_sel = mem_req;
	assign mem_lanes = vhp_lanes(bhe_s, a_reg[0]);
	// read data, registered
	always_ff @(posedge clock) begin
		if (rst) begin
			data_out <= 16'h0000;
		end else if (io_rd_start && io_hit) begin
			if (!reg_open) begin
				data_out <= 16'h0000;
			end else if (!a_s[0]) begin
				data_out <= {reg_index, reg_index};
			end else if (reg_index == VHP_GLOBAL_INDEX) begin
				data_out <= {2{VHP_VERSION, 2'b00, global_enable}};
			end else begin
				data_out <= {reg_rdata, reg_rdata};
			end
		end
	end
	logic [1:0] io_lanes, lanes;
	logic cycle_on, host_reads;
	assign io_lanes = vhp_lanes(bhe_s, a_s[0]);
	assign cycle_on = io_active || mem_req;
	assign lanes = io_active ? io_lanes : mem_lanes;
	assign host_reads = io_active ? !iord_s : !mrd_s;
	assign xcvr_dir = !host_reads;
	assign xcvr_low_byte_en_n = !(cycle_on && lanes[0]);
	assign xcvr_high_byte_en_n = !(cycle_on && lanes[1]);
	assign data_oe = cycle_on && host_reads && (!io_active || reg_open);
	assign irq = irq_enabled && vsync_pending;
	// ready sequencing for memory cycles
	vhp_rdy_type rdy_state;
	logic [7:0] wait_count;
	always_ff @(posedge clock) begin
		if (rst) begin
			rdy_state <= VHP_RDY_IDLE;
			wait_count <= 8'h00;
		end else begin
			case (rdy_state)
				VHP_RDY_IDLE: begin
					if (mem_req) begin
						rdy_state <= VHP_RDY_WAIT;
						wait_count <= 8'(WAIT_CYCLES);
					end
				end
				VHP_RDY_WAIT: begin
					if (!mem_req) begin
						rdy_state <= VHP_RDY_IDLE;
					end else if (wait_count > 8'h01 || mem_busy) begin
						wait_count <= (wait_count > 8'h01) ? wait_count - 8'h01 : wait_count;
					end else begin
						rdy_state <= VHP_RDY_HIGH;
					end
				end
				VHP_RDY_HIGH: begin
					if (!mem_req) rdy_state <= VHP_RDY_IDLE;
				end
				default: rdy_state <= VHP_RDY_IDLE;
			endcase
		end
	end
	assign ready_oe = rdy_state != VHP_RDY_IDLE;
	assign ready_out = rdy_state == VHP_RDY_HIGH;
	ready_release_a: assert property (@(posedge clock) disable iff (rst)
		!mem_req |=> !ready_oe) else $error("ready driven outside memory cycle");
	refresh_ignore_a: assert property (@(posedge clock) disable iff (rst)
		!system_refresh_n_s |-> !mem_sel) else $error("memory cycle during refresh");
	dir_read_a: assert property (@(posedge clock) disable iff (rst)
		io_active && !iord_s |-> !xcvr_dir) else $error("direction wrong on read");
	lane_low_a: assert property (@(posedge clock) disable iff (rst)
		!xcvr_low_byte_en_n |-> !iord_s || !iowr_s || !mrd_s || !mwr_s)
		else $error("low lane stray");
	aen_block_a: assert property (@(posedge clock) disable iff (rst)
		aen_s |=> !reg_wr && $stable(reg_index)) else $error("io decoded during dma");
	irq_level_a: assert property (@(posedge clock) disable iff (rst)
		irq_enabled && !vsync_pending |-> !irq) else $error("irq without pending");
	blocked_write_a: assert property (@(posedge clock) disable iff (rst)
		!reg_open |=> !reg_wr) else $error("register write while disabled");
	mem_gate_a: assert property (@(posedge clock) disable iff (rst)
		!global_enable[1] |-> memcs16_n && !mem_sel) else $error("memory open while off");
	addr_low_a: assert property (@(posedge clock) disable iff (rst)
		io_wr_pulse && a_s[7:1] != io_addr_reg[7:1] |=> $stable(reg_index) && !reg_wr)
		else $error("address mismatch");
	// a low phase ends either in ready high or in a dropped request
	sequence rdy_low_s;
		ready_oe && !ready_out;
	endsequence
	ready_order_a: assert property (@(posedge clock) disable iff (rst)
		rdy_low_s ##1 !rdy_low_s |-> ready_out || !$past(mem_req))
		else $error("ready left low phase wrongly");
endmodule
`default_nettype wire

// ### vhp_pkg.sv
// Purpose: constants for the video host bus port
// Assumes: 125 MHz clock, bus pins sampled through two flip-flops
// Notes: index and data share an even/odd I/O pair
// Notes on behaviour
// - refresh low cancels current memory cycle
// - direction 0 on host read, 1 on write
// - steer bytes from high enable and a0
// - io strobes ignored while aen high
// - address captured on ale falling edge
// - ready released, pulled low, driven high, released
// - memcs16 low in word-capable memory region
// - interrupt high while vsync pending, enabled
// - chip select low at reset: fixed pair
// - fixed mode needs chip select during access
// - else first selected io write loads address
// - ignore address bit 0, match low byte
// - index at even, data at odd location
// - other registers blocked until enable bit 0
// - before enable only index/enable writes, no reads
// - fixed mode address register reset value
// - compare register bits 7:1 with a7:1
// - frame buffer only while enable bit 1
`default_nettype none
package vhp_pkg;
	localparam logic [7:0] VHP_FIXED_ADDR = 8'hD6;
	localparam logic [7:0] VHP_GLOBAL_INDEX = 8'hFF;
	localparam int VHP_REG_EN_BIT = 0;
	localparam int VHP_MEM_EN_BIT = 1;
	localparam logic [3:0] VHP_VERSION = 4'h1; // arbitrary value
	localparam int VHP_CLK_MHZ = 125;
	localparam int VHP_WAIT_NS = 120;
	localparam int VHP_WAIT_CYCLES = (VHP_WAIT_NS * VHP_CLK_MHZ + 999) / 1000;
	localparam logic [3:0] VHP_MEM_BASE_RESET = 4'h1;
	typedef enum {VHP_RDY_IDLE, VHP_RDY_WAIT, VHP_RDY_HIGH} vhp_rdy_type;
	function automatic logic [1:0] vhp_lanes(input logic bhe_n, input logic a0);
		vhp_lanes = {~bhe_n, ~a0};
	endfunction
endpackage
`default_nettype wire

// ### vhp_sync.sv
// Purpose: two-flip-flop synchroniser for a bus of pin levels
// Assumes: inputs asynchronous to clock
// Notes: first stage read only by second stage
`default_nettype none
module vhp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_reg <= INIT;
			q <= INIT;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire
